// ===== qdb_pkg.sv
package qdb_pkg;

    // Clocking: the controller divides the system clock down to the link clock
    localparam int SYS_CLK_PERIOD_NS  = 100;
    localparam int LINK_CLK_PERIOD_NS = 800;
    localparam int LINK_DIV           = LINK_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
    localparam int LINK_HALF          = LINK_DIV / 2;
    localparam int LINK_QTR           = LINK_DIV / 4;
    localparam int LINK_CNT_W         = $clog2(LINK_DIV);

    // Burst shape
    localparam int         BURST_LEN  = 4;
    localparam int         BEAT_W     = 2;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_LAST  = 2'h3;

    // Default geometry: 8-bit data, 4-bit nybble lanes
    localparam int DEF_AW = 6;
    localparam int DEF_DW = 8;
    localparam int DEF_LW = 4;

    // Buffer
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        CT_IDLE,
        CT_ISSUED,
        CT_WRITE,
        CT_READ
    } qdb_ctl_state_e;

endpackage

// ===== qdb_if.sv
`timescale 1ns/1ps
interface qdb_if #(
    parameter int AW = qdb_pkg::DEF_AW,
    parameter int DW = qdb_pkg::DEF_DW,
    parameter int LW = qdb_pkg::DEF_LW
);
    localparam int ML = DW / LW;

    logic          in_clk;
    logic          in_clk_n;
    logic          out_clk;
    logic          out_clk_n;
    logic          rd_sel_n;
    logic          wr_sel_n;
    logic          dll_off_n;
    logic [AW-1:0] sync_address_in;
    logic [DW-1:0] write_data_in;
    logic [ML-1:0] nybble_lane_mask_n;
    logic [DW-1:0] read_data_out;
    logic          echo_strobe;
    logic          echo_strobe_n;

    modport dev (
        input  in_clk,
        input  in_clk_n,
        input  out_clk,
        input  out_clk_n,
        input  rd_sel_n,
        input  wr_sel_n,
        input  dll_off_n,
        input  sync_address_in,
        input  write_data_in,
        input  nybble_lane_mask_n,
        output read_data_out,
        output echo_strobe,
        output echo_strobe_n
    );

    modport ctl (
        output in_clk,
        output in_clk_n,
        output out_clk,
        output out_clk_n,
        output rd_sel_n,
        output wr_sel_n,
        output dll_off_n,
        output sync_address_in,
        output write_data_in,
        output nybble_lane_mask_n,
        input  read_data_out,
        input  echo_strobe,
        input  echo_strobe_n
    );
endinterface

// ===== qdb_buf2.sv
`timescale 1ns/1ps
module qdb_buf2 #(
    parameter int W = qdb_pkg::DEF_DW
) (
    // System
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [1:0]   cnt_q;
    logic [W-1:0] slot0_q;
    logic [W-1:0] slot1_q;
    logic         push;
    logic         pop;

    assign in_ready  = (cnt_q != 2'(qdb_pkg::BUF_DEPTH));
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = slot0_q;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            slot0_q <= '0;
            slot1_q <= '0;
        end else begin
            if (pop) begin
                if (cnt_q == 2'h2) begin
                    slot0_q <= slot1_q;
                end else if (push) begin
                    slot0_q <= in_data;
                end
            end else if (push) begin
                if (cnt_q == 2'h0) begin
                    slot0_q <= in_data;
                end else begin
                    slot1_q <= in_data;
                end
            end
        end
    end
endmodule

// ===== qdb_sram.sv
`timescale 1ns/1ps
// Operation
// - Sample address and selects on true-clock rise
// - Both selects high means deselect, nothing starts
// - Read select low starts a read burst
// - Read ignored right after an accepted read
// - Write low with read high starts write
// - Write ignored right after an accepted write
// - Write beats on true, comp, true, comp
// - Read data leaves after next true-clock rise
// - One address moves four data words
// - Masks sampled with their own data beat
// - Masked lane keeps its old contents
// - Masking works per lane, any burst
// - Controller may vary masks on every beat
// - Mask 0 gates bits 3:0, mask 1 bits 7:4
// - Write commands never disturb reads; a read blocks a write on the same rise
// - Started bursts always run to completion
// - Output clock pair launches read data
// - Output clocks both high select input clocks
// - Low DLL disable input turns alignment off
// - Burst address low bits count from zero
// - Read and write sequencers run concurrently
module qdb_sram #(
    parameter int AW = qdb_pkg::DEF_AW,
    parameter int DW = qdb_pkg::DEF_DW,
    parameter int LW = qdb_pkg::DEF_LW
) (
    // System
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Link
    qdb_if.dev        lnk,
    // Status
    output logic      dll_active
);
    localparam int ML = DW / LW;
    localparam int SW = 7 + AW + DW + ML;
    localparam int MA = AW + qdb_pkg::BEAT_W;
    // Idle pin levels, so no false clock edge follows reset
    localparam logic [SW-1:0] SYNC_IDLE = {4'h7, 3'h6, {AW{1'b0}}, {DW{1'b0}}, {ML{1'b1}}};

    // Every link pin passes two flops before use
    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;

    logic          k_s;
    logic          kn_s;
    logic          c_s;
    logic          cn_s;
    logic          rsel_n_s;
    logic          wsel_n_s;
    logic          dll_off_n_s;
    logic [AW-1:0] addr_s;
    logic [DW-1:0] wdat_s;
    logic [ML-1:0] mask_n_s;

    logic k_p_q;
    logic kn_p_q;
    logic c_p_q;
    logic cn_p_q;
    logic kr;
    logic knr;
    logic cr;
    logic cnr;
    logic c_tied;
    logic fire_t_raw;
    logic fire_c_raw;
    logic fire_t_dly_q;
    logic fire_c_dly_q;
    logic fire_t;
    logic fire_c;

    logic prev_rd_q;
    logic prev_wr_q;
    logic rd_go;
    logic wr_go;

    logic          rpend_q;
    logic [AW-1:0] rpend_addr_q;
    logic          rarm_q;
    logic          ract_q;
    logic [1:0]    rbeat_q;
    logic [AW-1:0] raddr_q;
    logic          launch0;
    logic          launchn;

    logic          wpend_q;
    logic [AW-1:0] wpend_addr_q;
    logic          wact_q;
    logic [1:0]    wbeat_q;
    logic [AW-1:0] waddr_q;
    logic          cap0;
    logic          capn;
    logic [MA-1:0] wr_index;

    logic [DW-1:0] mem [0:(1 << MA)-1];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_q <= SYNC_IDLE;
            s2_q <= SYNC_IDLE;
        end else begin
            s1_q <= {lnk.in_clk, lnk.in_clk_n, lnk.out_clk, lnk.out_clk_n, lnk.rd_sel_n, lnk.wr_sel_n,
                     lnk.dll_off_n, lnk.sync_address_in, lnk.write_data_in, lnk.nybble_lane_mask_n};
            s2_q <= s1_q;
        end
    end

    assign {k_s, kn_s, c_s, cn_s, rsel_n_s, wsel_n_s, dll_off_n_s, addr_s, wdat_s, mask_n_s} = s2_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            k_p_q  <= 1'b0;
            kn_p_q <= 1'b1;
            c_p_q  <= 1'b1;
            cn_p_q <= 1'b1;
        end else begin
            k_p_q  <= k_s;
            kn_p_q <= kn_s;
            c_p_q  <= c_s;
            cn_p_q <= cn_s;
        end
    end

    assign kr  = k_s & ~k_p_q;
    assign knr = kn_s & ~kn_p_q;
    assign cr  = c_s & ~c_p_q;
    assign cnr = cn_s & ~cn_p_q;

    // Running output clocks are complements, so both high only when tied off
    assign c_tied     = c_s & cn_s;
    assign fire_t_raw = c_tied ? kr : cr;
    assign fire_c_raw = c_tied ? knr : cnr;

    // Without the alignment loop the launch slips one system cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fire_t_dly_q <= 1'b0;
            fire_c_dly_q <= 1'b0;
            dll_active   <= 1'b0;
        end else begin
            fire_t_dly_q <= fire_t_raw;
            fire_c_dly_q <= fire_c_raw;
            dll_active   <= dll_off_n_s;
        end
    end

    assign fire_t = dll_active ? fire_t_raw : fire_t_dly_q;
    assign fire_c = dll_active ? fire_c_raw : fire_c_dly_q;

    // Command decode, only at true-clock rises
    assign rd_go = kr & ~rsel_n_s & ~prev_rd_q;
    assign wr_go = kr & rsel_n_s & ~wsel_n_s & ~prev_wr_q;

    // A deselect or ignored edge counts as the previous command
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prev_rd_q <= 1'b0;
            prev_wr_q <= 1'b0;
        end else if (kr) begin
            prev_rd_q <= rd_go;
            prev_wr_q <= wr_go;
        end
    end

    // Read sequencer, independent of the write side
    assign launch0 = fire_t & (rarm_q | (rpend_q & kr));
    assign launchn = ~launch0 & ract_q & (rbeat_q[0] ? fire_c : fire_t);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rpend_q      <= 1'b0;
            rpend_addr_q <= '0;
            rarm_q       <= 1'b0;
        end else begin
            if (rd_go) begin
                rpend_q      <= 1'b1;
                rpend_addr_q <= addr_s;
            end else if (kr && rpend_q) begin
                rpend_q <= 1'b0;
                rarm_q  <= ~launch0;
            end
            if (launch0) begin
                rarm_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ract_q            <= 1'b0;
            rbeat_q           <= qdb_pkg::BEAT_FIRST;
            raddr_q           <= '0;
            lnk.read_data_out <= '0;
            lnk.echo_strobe   <= 1'b0;
            lnk.echo_strobe_n <= 1'b0;
        end else if (launch0) begin
            ract_q            <= 1'b1;
            rbeat_q           <= qdb_pkg::BEAT_FIRST + 2'h1;
            raddr_q           <= rpend_addr_q;
            lnk.read_data_out <= mem[{rpend_addr_q, qdb_pkg::BEAT_FIRST}];
            lnk.echo_strobe   <= 1'b1;
            lnk.echo_strobe_n <= 1'b0;
        end else if (launchn) begin
            rbeat_q           <= rbeat_q + 2'h1;
            ract_q            <= (rbeat_q != qdb_pkg::BEAT_LAST);
            lnk.read_data_out <= mem[{raddr_q, rbeat_q}];
            lnk.echo_strobe   <= ~rbeat_q[0];
            lnk.echo_strobe_n <= rbeat_q[0];
        end else if (fire_t || fire_c) begin
            // Data holds its last value; strobes stop so no beat is implied
            lnk.echo_strobe   <= 1'b0;
            lnk.echo_strobe_n <= 1'b0;
        end
    end

    // Write sequencer, independent of the read side
    assign cap0 = kr & wpend_q;
    assign capn = ~cap0 & wact_q & (wbeat_q[0] ? knr : kr);
    assign wr_index = cap0 ? {wpend_addr_q, qdb_pkg::BEAT_FIRST} : {waddr_q, wbeat_q};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wpend_q      <= 1'b0;
            wpend_addr_q <= '0;
            wact_q       <= 1'b0;
            wbeat_q      <= qdb_pkg::BEAT_FIRST;
            waddr_q      <= '0;
        end else begin
            if (wr_go) begin
                wpend_q      <= 1'b1;
                wpend_addr_q <= addr_s;
            end else if (cap0) begin
                wpend_q <= 1'b0;
            end
            if (cap0) begin
                wact_q  <= 1'b1;
                wbeat_q <= qdb_pkg::BEAT_FIRST + 2'h1;
                waddr_q <= wpend_addr_q;
            end else if (capn) begin
                wbeat_q <= wbeat_q + 2'h1;
                wact_q  <= (wbeat_q != qdb_pkg::BEAT_LAST);
            end
        end
    end

    // Storage has no reset, as in a real array
    always_ff @(posedge clk_sys) begin
        if (cap0 || capn) begin
            for (int l = 0; l < ML; l++) begin
                if (!mask_n_s[l]) begin
                    mem[wr_index][l*LW +: LW] <= wdat_s[l*LW +: LW];
                end
            end
        end
    end
endmodule

// ===== qdb_ctrl.sv
`timescale 1ns/1ps
module qdb_ctrl #(
    parameter int AW            = qdb_pkg::DEF_AW,
    parameter int DW            = qdb_pkg::DEF_DW,
    parameter int LW            = qdb_pkg::DEF_LW,
    parameter bit OUT_CLK_TIED  = 1'b0
) (
    // System
    input  wire logic                              clk_sys,
    input  wire logic                              nrst,
    // Link
    qdb_if.ctl                                     lnk,
    // Command
    input  wire logic                              cmd_valid,
    output logic                                   cmd_ready,
    input  wire logic                              cmd_write,
    input  wire logic [AW-1:0]                     cmd_addr,
    input  wire logic [qdb_pkg::BURST_LEN*DW-1:0]  cmd_wdata,
    input  wire logic [qdb_pkg::BURST_LEN*DW/LW-1:0] cmd_mask_n,
    // Read return
    output logic                                   rd_valid,
    input  wire logic                              rd_ready,
    output logic [DW-1:0]                          rd_data,
    // Control
    input  wire logic                              dll_enable
);
    localparam int ML = DW / LW;
    localparam int CW = qdb_pkg::LINK_CNT_W;

    logic [CW-1:0] cnt_q;
    logic          tick_q1;
    logic          tick_q3;
    logic          kq;

    qdb_pkg::qdb_ctl_state_e state_q;
    logic                          is_wr_q;
    logic [2:0]                    beat_q;
    logic [qdb_pkg::BURST_LEN*DW-1:0] wbuf_q;
    logic [qdb_pkg::BURST_LEN*ML-1:0] mbuf_q;

    logic [DW+1:0] e1_q;
    logic [DW+1:0] e2_q;
    logic          es_p_q;
    logic          esn_p_q;
    logic          echo_edge;
    logic [DW-1:0] hold_q [0:qdb_pkg::BURST_LEN-1];
    logic [1:0]    cap_idx_q;
    logic [2:0]    unl_left_q;
    logic [1:0]    unl_ptr_q;
    logic          buf_in_ready;

    // Link clock divider; data moves at quarter points, clear of both edges
    assign tick_q1 = (cnt_q == CW'(qdb_pkg::LINK_QTR));
    assign tick_q3 = (cnt_q == CW'(qdb_pkg::LINK_DIV - qdb_pkg::LINK_QTR));
    assign kq      = (cnt_q < CW'(qdb_pkg::LINK_HALF));

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q         <= '0;
            lnk.in_clk    <= 1'b0;
            lnk.in_clk_n  <= 1'b1;
            lnk.out_clk   <= 1'b1;
            lnk.out_clk_n <= 1'b1;
            lnk.dll_off_n <= 1'b0;
        end else begin
            cnt_q         <= (cnt_q == CW'(qdb_pkg::LINK_DIV - 1)) ? '0 : cnt_q + CW'(1);
            lnk.in_clk    <= kq;
            lnk.in_clk_n  <= ~kq;
            lnk.out_clk   <= OUT_CLK_TIED ? 1'b1 : lnk.in_clk;
            lnk.out_clk_n <= OUT_CLK_TIED ? 1'b1 : lnk.in_clk_n;
            lnk.dll_off_n <= dll_enable;
        end
    end

    // At most one command per four link periods keeps the device's ignore window clear
    assign cmd_ready = (state_q == qdb_pkg::CT_IDLE) && tick_q3 && (unl_left_q == 3'h0);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q                <= qdb_pkg::CT_IDLE;
            is_wr_q                <= 1'b0;
            beat_q                 <= 3'h0;
            wbuf_q                 <= '0;
            mbuf_q                 <= '1;
            lnk.rd_sel_n           <= 1'b1;
            lnk.wr_sel_n           <= 1'b1;
            lnk.sync_address_in    <= '0;
            lnk.write_data_in      <= '0;
            lnk.nybble_lane_mask_n <= '1;
        end else begin
            unique case (state_q)
                qdb_pkg::CT_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        lnk.rd_sel_n        <= cmd_write;
                        lnk.wr_sel_n        <= ~cmd_write;
                        lnk.sync_address_in <= cmd_addr;
                        is_wr_q             <= cmd_write;
                        wbuf_q              <= cmd_wdata;
                        mbuf_q              <= cmd_mask_n;
                        state_q             <= qdb_pkg::CT_ISSUED;
                    end
                end
                qdb_pkg::CT_ISSUED: begin
                    if (tick_q3) begin
                        lnk.rd_sel_n <= 1'b1;
                        lnk.wr_sel_n <= 1'b1;
                        if (is_wr_q) begin
                            lnk.write_data_in      <= wbuf_q[0 +: DW];
                            lnk.nybble_lane_mask_n <= mbuf_q[0 +: ML];
                            beat_q                 <= 3'h1;
                            state_q                <= qdb_pkg::CT_WRITE;
                        end else begin
                            state_q <= qdb_pkg::CT_READ;
                        end
                    end
                end
                qdb_pkg::CT_WRITE: begin
                    if (beat_q == 3'(qdb_pkg::BURST_LEN)) begin
                        if (tick_q3) begin
                            lnk.nybble_lane_mask_n <= '1;
                            state_q                <= qdb_pkg::CT_IDLE;
                        end
                    end else if (beat_q[0] ? tick_q1 : tick_q3) begin
                        lnk.write_data_in      <= wbuf_q[beat_q[1:0]*DW +: DW];
                        lnk.nybble_lane_mask_n <= mbuf_q[beat_q[1:0]*ML +: ML];
                        beat_q                 <= beat_q + 3'h1;
                    end
                end
                qdb_pkg::CT_READ: begin
                    if (echo_edge && cap_idx_q == qdb_pkg::BEAT_LAST) begin
                        state_q <= qdb_pkg::CT_IDLE;
                    end
                end
            endcase
        end
    end

    // Returned data and echo strobes cross in through two flops
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            e1_q    <= '0;
            e2_q    <= '0;
            es_p_q  <= 1'b0;
            esn_p_q <= 1'b0;
        end else begin
            e1_q    <= {lnk.echo_strobe, lnk.echo_strobe_n, lnk.read_data_out};
            e2_q    <= e1_q;
            es_p_q  <= e2_q[DW+1];
            esn_p_q <= e2_q[DW];
        end
    end

    assign echo_edge = (state_q == qdb_pkg::CT_READ) && ((e2_q[DW+1] & ~es_p_q) | (e2_q[DW] & ~esn_p_q));

    // Whole burst is held, then fed to the buffer only as it accepts
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cap_idx_q  <= qdb_pkg::BEAT_FIRST;
            unl_left_q <= 3'h0;
            unl_ptr_q  <= 2'h0;
            for (int i = 0; i < qdb_pkg::BURST_LEN; i++) begin
                hold_q[i] <= '0;
            end
        end else begin
            if (echo_edge) begin
                hold_q[cap_idx_q] <= e2_q[DW-1:0];
                cap_idx_q         <= cap_idx_q + 2'h1;
                if (cap_idx_q == qdb_pkg::BEAT_LAST) begin
                    unl_left_q <= 3'(qdb_pkg::BURST_LEN);
                    unl_ptr_q  <= 2'h0;
                end
            end else if (unl_left_q != 3'h0 && buf_in_ready) begin
                unl_left_q <= unl_left_q - 3'h1;
                unl_ptr_q  <= unl_ptr_q + 2'h1;
            end
        end
    end

    qdb_buf2 #(
        .W (DW)
    ) u_rd_buf (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (unl_left_q != 3'h0),
        .in_ready  (buf_in_ready),
        .in_data   (hold_q[unl_ptr_q]),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );
endmodule

// ===== qdb_link_properties.sv
`timescale 1ns/1ps
module qdb_link_chk #(
    parameter int DW           = 8,
    parameter bit OUT_CLK_TIED = 1'b0
) (
    // System
    input wire logic          clk_sys,
    input wire logic          nrst,
    // Link
    input wire logic          in_clk,
    input wire logic          out_clk,
    input wire logic          rd_sel_n,
    input wire logic [DW-1:0] read_data_out,
    input wire logic          echo_strobe,
    input wire logic          echo_strobe_n
);
    logic [5:0] idle_q;
    logic [1:0] up_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Cycles since the last read select, saturating
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) idle_q <= '0;
        else if (!rd_sel_n) idle_q <= '0;
        else if (idle_q != 6'h3F) idle_q <= idle_q + 6'h01;
    end

    // Output clocks lag reset release by two flops
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) up_q <= '0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end

    sequence s_read_beats;
        ##[1:40] $rose(echo_strobe) ##[1:8] $rose(echo_strobe_n);
    endsequence

    a_read_launch: assert property ($fell(rd_sel_n) |-> s_read_beats)
        else $error("read burst did not launch in time");
    a_echo_excl: assert property (!(echo_strobe && echo_strobe_n))
        else $error("both echo strobes high");
    a_link_period: assert property ($rose(in_clk) |-> in_clk [*4] ##1 !in_clk [*4])
        else $error("link clock period wrong");
    a_data_echo: assert property ($changed(read_data_out) |-> echo_strobe || echo_strobe_n)
        else $error("read data moved without echo");
    a_sel_setup: assert property ($rose(in_clk) |-> $stable(rd_sel_n))
        else $error("read select changed at link edge");
    a_rd_width: assert property ($fell(rd_sel_n) |-> !rd_sel_n [*8] ##1 rd_sel_n)
        else $error("read select width wrong");
    a_out_clk: assert property (up_q == 2'h3 |-> out_clk == (OUT_CLK_TIED | $past(in_clk)))
        else $error("output clock does not follow link clock");
    a_echo_order: assert property ($rose(echo_strobe_n) |-> $past(echo_strobe))
        else $error("odd beat without even beat before");
    a_idle_quiet: assert property (idle_q == 6'h3F |-> $stable(read_data_out) && !echo_strobe)
        else $error("read data while idle");
endmodule

// ===== quad_ddr_burst4_sram_port_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module quad_ddr_burst4_sram_port_test;
    logic        clk_sys    = 1'b0;
    logic        nrst       = 1'b0;
    logic        cmd_valid  = 1'b0;
    logic        cmd_ready;
    logic        cmd_write  = 1'b0;
    logic [5:0]  cmd_addr   = '0;
    logic [31:0] cmd_wdata  = '0;
    logic [7:0]  cmd_mask_n = '0;
    logic        rd_valid;
    logic        rd_ready   = 1'b1;
    logic [7:0]  rd_data;
    logic        dll_enable = 1'b1;
    logic        dll_active;
    logic        cmd_ready_k;
    logic        rd_valid_k;
    logic [7:0]  rd_data_k;
    logic        dll_active_k;
    logic [7:0]  exp_mem [0:255];
    int          num_errors = 0;
    int          n_tests    = 0;

    qdb_if lnk ();
    qdb_sram qdb_sram_inst (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk.dev), .dll_active(dll_active));
    qdb_ctrl qdb_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk.ctl), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_mask_n(cmd_mask_n), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .dll_enable(dll_enable));
    // Second pair ties the output clocks, so reads fire from the link clock
    qdb_if lnk_k ();
    qdb_sram qdb_sram_k_inst (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk_k.dev), .dll_active(dll_active_k));
    qdb_ctrl #(.OUT_CLK_TIED(1'b1)) qdb_ctrl_k_inst (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk_k.ctl),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready_k), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_mask_n(cmd_mask_n), .rd_valid(rd_valid_k), .rd_ready(rd_ready),
        .rd_data(rd_data_k), .dll_enable(dll_enable));
    qdb_link_chk #(.DW(8), .OUT_CLK_TIED(1'b0)) qdb_link_chk_inst (.clk_sys(clk_sys), .nrst(nrst),
        .in_clk(lnk.in_clk), .out_clk(lnk.out_clk), .rd_sel_n(lnk.rd_sel_n),
        .read_data_out(lnk.read_data_out), .echo_strobe(lnk.echo_strobe), .echo_strobe_n(lnk.echo_strobe_n));

    always #50 clk_sys = ~clk_sys;

    task automatic conclude();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Holds the request until the one-cycle ready pulse is sampled
    task automatic issue(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [7:0] m);
        int n;
        n = 0;
        @(posedge clk_sys);
        cmd_valid  <= 1'b1;
        cmd_write  <= wr;
        cmd_addr   <= a;
        cmd_wdata  <= d;
        cmd_mask_n <= m;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cmd_ready !== 1'b1 && n < 300);
        cmd_valid <= 1'b0;
        `CHK("cmd_ready", 1'b1, cmd_ready)
        `CHK("cmd_ready_k", 1'b1, cmd_ready_k)
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [7:0] m);
        issue(1'b1, a, d, m);
        for (int b = 0; b < 4; b++)
            for (int l = 0; l < 2; l++)
                if (!m[b*2+l]) exp_mem[{a, b[1:0]}][l*4 +: 4] = d[b*8+l*4 +: 4];
    endtask

    // Receiver stalls first, so the hold registers and buffer must keep the burst
    task automatic rd(input logic [5:0] a, input int stall);
        int b;
        int bk;
        int n;
        b = 0;
        bk = 0;
        n = 0;
        rd_ready <= 1'b0;
        issue(1'b0, a, '0, '0);
        repeat (stall) @(posedge clk_sys);
        rd_ready <= 1'b1;
        while ((b < 4 || bk < 4) && n < 300) begin
            @(posedge clk_sys);
            n++;
            if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
                `CHK("rd_data", exp_mem[{a, b[1:0]}], rd_data)
                b++;
            end
            if (rd_valid_k === 1'b1 && rd_ready === 1'b1) begin
                `CHK("rd_data_k", exp_mem[{a, bk[1:0]}], rd_data_k)
                bk++;
            end
        end
        `CHK("words", 4, b)
        `CHK("words_k", 4, bk)
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        wr(6'h05, 32'h44332211, 8'h00);
        rd(6'h05, 0);
        // Beat masks 01, 10, 00, 11: each lane kept on its own beat
        wr(6'h05, 32'hDDCCBBAA, 8'hC9);
        rd(6'h05, 40);
        wr(6'h3F, 32'h0F1E2D3C, 8'h00);
        rd(6'h3F, 0);
        rd(6'h05, 0);
        `CHK("dll_active", 1'b1, dll_active)
        `CHK("dll_active_k", 1'b1, dll_active_k)
        dll_enable <= 1'b0;
        rd(6'h3F, 0);
        `CHK("dll_active", 1'b0, dll_active)
        `CHK("dll_active_k", 1'b0, dll_active_k)
        repeat (70) @(posedge clk_sys);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        conclude();
    end
endmodule
